/* dv/ppc_sink_model.sv */
// converter-side sink model: takes pixels under a stallable ready
// assumes the block's clock and its synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module ppc_sink_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [23:0] conv_pix,
	input wire logic conv_valid,
	input wire logic stall,
	output logic conv_ready,
	output logic [23:0] rx_pix,
	output logic rx_stb
);
	// ready moves only after an edge; a pixel counts where valid meets ready
	always_ff @(posedge ref_clk) begin
		conv_ready <= !rst && !stall;
		rx_stb <= !rst && conv_valid && conv_ready;
		rx_pix <= conv_pix;
	end
endmodule : ppc_sink_model
`default_nettype wire

/* dv/ppc_top_tb.sv */
// self-checking bench for the pixel pipeline and cursor 1 configuration block
// assumes the sink model on the converter side and one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ppc_top_tb;
	import ppc_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, host_sel_data = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
	logic conv_rd = 1'b0, pix_valid = 1'b0, pix_rep = 1'b0, pix_last = 1'b0, stall = 1'b1;
	logic de_in = 1'b0, blank_in = 1'b1, csync = 1'b0, blink = 1'b0, pix_ready, conv_valid;
	logic conv_ready, rx_stb, crt_de, crt_blank, green_sync, pedestal, fp_ovs, crt_ovs;
	logic ext_pal, gfx_g, vid_g, k_show, k_vs, k_hs, k_org;
	logic [7:0] host_wdata = 8'h00, ext_h = 8'h00, host_rdata, conv_rdata;
	logic [5:0] sm_status = 6'h2d;
	logic [31:0] s0 = 32'h0, s1 = 32'h0;
	logic [23:0] conv_pix, rx_pix;
	logic [1:0] eng = 2'b01;
	logic [9:0] k_h;
	ppc_port_type conv_port = 2'h0;
	ppc_cmode_type cmode;
	ppc_kmode_type kmode;
	int num_errors = 0, checks = 0;

	// 40 ns period
	always #20 ref_clk = ~ref_clk;

	ppc_top DUT (.ref_clk(ref_clk), .rst(rst), .host_sel_data(host_sel_data),
		.host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.conv_rd(conv_rd), .conv_port(conv_port), .conv_mask_val(8'h11), .conv_wx_val(8'h22),
		.conv_state_val(8'h33), .red_hold(8'h44), .green_hold(8'h55), .sm_status(sm_status),
		.conv_rdata(conv_rdata), .first_pixel_stream(s0), .second_pixel_stream(s1),
		.pix_valid(pix_valid), .pix_replicated(pix_rep), .pix_last(pix_last),
		.pix_ready(pix_ready), .conv_pix(conv_pix), .conv_valid(conv_valid),
		.conv_ready(conv_ready), .display_engine_select(eng), .crt_de_in(de_in),
		.crt_blank_in(blank_in), .csync_in(csync), .crt_de(crt_de), .crt_blank(crt_blank),
		.green_sync(green_sync), .blank_pedestal(pedestal), .fp_border_protected(fp_ovs),
		.crt_border_protected(crt_ovs), .ext_palette_access(ext_pal), .color_mode(cmode),
		.gfx_through_palette(gfx_g), .video_through_palette(vid_g), .blink_phase(blink),
		.cursor_one_height_extension(ext_h), .cursor1_show(k_show), .cursor1_vstretch(k_vs),
		.cursor1_hstretch(k_hs), .cursor1_active_origin(k_org), .cursor1_height(k_h),
		.cursor1_mode(kmode));

	ppc_sink_model SINK (.ref_clk(ref_clk), .rst(rst), .conv_pix(conv_pix),
		.conv_valid(conv_valid), .stall(stall), .conv_ready(conv_ready), .rx_pix(rx_pix),
		.rx_stb(rx_stb));

	// verdict and end of run
	task automatic test_done;
		if (num_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done

	// one host port access, strobe held for exactly one edge
	task automatic host(input logic sel, input logic [7:0] d);
		@(posedge ref_clk);
		host_sel_data <= sel;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge ref_clk);
		host_wr <= 1'b0;
	endtask : host

	// index then data, then let the registered outputs follow
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		host(1'b0, i);
		host(1'b1, d);
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] i, output logic [7:0] v);
		host(1'b0, i);
		@(posedge ref_clk);
		host_sel_data <= 1'b1;
		host_rd <= 1'b1;
		@(posedge ref_clk);
		host_rd <= 1'b0;
		#1 v = host_rdata;
	endtask : rd

	task automatic crd(input ppc_port_type p, output logic [7:0] v);
		@(posedge ref_clk);
		conv_port <= p;
		conv_rd <= 1'b1;
		@(posedge ref_clk);
		conv_rd <= 1'b0;
		#1 v = conv_rdata;
	endtask : crd

	// pixel held until an edge that sees ready high
	task automatic px(input logic [31:0] a, input logic [31:0] b, input logic rp, input logic l);
		@(posedge ref_clk);
		s0 <= a;
		s1 <= b;
		pix_rep <= rp;
		pix_last <= l;
		pix_valid <= 1'b1;
		#1;
		for (int n = 0; n < 20 && !pix_ready; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (!pix_ready) num_errors++;
		@(posedge ref_clk);
		pix_valid <= 1'b0;
		#1;
	endtask : px

	// next pixel taken by the sink, unknown on timeout
	task automatic get(output logic [23:0] v);
		v = 'x;
		for (int n = 0; n < 40; n++) begin
			@(posedge ref_clk);
			#1;
			if (rx_stb) begin
				v = rx_pix;
				break;
			end
		end
	endtask : get

	function automatic logic [23:0] dac(input logic [31:0] d, input logic b8);
		return b8 ? d[23:0] : {2'b00, d[23:18], 2'b00, d[15:10], 2'b00, d[7:2]};
	endfunction : dac

	function automatic logic [23:0] mean(input logic [23:0] a, input logic [23:0] b);
		logic [8:0] s [3];
		for (int k = 0; k < 3; k++) s[k] = a[k*8 +: 8] + b[k*8 +: 8];
		return {s[2][8:1], s[1][8:1], s[0][8:1]};
	endfunction : mean

	// reset values, write masks, unmapped index, level outputs
	task automatic t_regs;
		logic [7:0] v;
		logic [7:0] idx [5] = '{8'h80, 8'h81, 8'h82, 8'ha0, 8'h90};
		logic [7:0] msk [5] = '{8'hff, 8'h1f, 8'h0f, 8'hff, 8'h00};
		for (int k = 0; k < 5; k++) begin
			rd(idx[k], v);
			`CHK(v, 8'h00)
			wr(idx[k], 8'hff);
			rd(idx[k], v);
			`CHK(v, msk[k])
		end
		`CHK({fp_ovs, crt_ovs, ext_pal, vid_g, pedestal}, 5'h1f)
		@(posedge ref_clk);
		csync <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 `CHK(green_sync, 1'b1)
		wr(8'h82, 8'h08);
		`CHK({vid_g, pedestal, green_sync}, 3'b000)
	endtask : t_regs

	// colour modes with graphics gamma on
	task automatic t_cmode;
		logic [3:0] cm [6] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
		for (int k = 0; k < 6; k++) begin
			wr(8'h81, {4'h0, cm[k]});
			`CHK(cmode, cm[k])
			`CHK(gfx_g, cm[k] >= 4'h4)
		end
	endtask : t_cmode

	// converter port reads, normal then extended status
	task automatic t_ext;
		logic [7:0] v;
		logic [7:0] nrm [3] = '{8'h11, 8'h22, 8'h33};
		logic [7:0] ext [3] = '{8'h44, 8'h55, {6'h2d, 2'b00}};
		wr(8'h80, 8'h00);
		for (int k = 0; k < 3; k++) begin
			crd(k[1:0], v);
			`CHK(v, nrm[k])
		end
		wr(8'h80, 8'h08);
		for (int k = 0; k < 3; k++) begin
			crd(k[1:0], v);
			`CHK(v, ext[k])
		end
	endtask : t_ext

	// width and stream choice; top byte of each dword must not leak
	task automatic t_pix;
		logic [23:0] v;
		logic [7:0] cf [3] = '{8'h00, 8'h80, 8'hc0};
		for (int k = 0; k < 3; k++) begin
			wr(8'h80, cf[k]);
			px(32'hff12_3456, 32'hee9a_bcde, 1'b0, 1'b1);
			stall <= 1'b0;
			get(v);
			`CHK(v, dac(cf[k][6] ? 32'h009a_bcde : 32'h0012_3456, cf[k][7]))
			stall <= 1'b1;
		end
	endtask : t_pix

	// fill the buffer against a stalled sink, then drain in order
	task automatic t_fill;
		logic [23:0] v;
		int n;
		n = 0;
		wr(8'h80, 8'h00);
		while (n < 10 && pix_ready) begin
			px(n * 32'h0001_0203, 32'h0, 1'b0, 1'b1);
			n++;
		end
		`CHK(n >= 4 && n <= 6, 1'b1)
		stall <= 1'b0;
		for (int k = 0; k < n; k++) begin
			get(v);
			`CHK(v, dac(k * 32'h0001_0203, 1'b0))
		end
		stall <= 1'b1;
	endtask : t_fill

	// flat panel averaging of a replica with its follower
	task automatic t_avg;
		logic [23:0] v;
		wr(8'h80, 8'ha0);
		eng <= 2'b10;
		px(32'h0010_20ff, 32'h0, 1'b1, 1'b0);
		px(32'h0033_4401, 32'h0, 1'b0, 1'b1);
		stall <= 1'b0;
		get(v);
		`CHK(v, mean(24'h1020ff, 24'h334401))
		get(v);
		`CHK(v, 24'h334401)
		stall <= 1'b1;
	endtask : t_avg

	// one enable pulse and one blank gap through the crt path
	task automatic crt(input logic [1:0] e, input logic [7:0] c1, input logic dly);
		wr(8'h81, c1);
		@(posedge ref_clk);
		eng <= e;
		de_in <= 1'b1;
		blank_in <= 1'b0;
		@(posedge ref_clk);
		de_in <= 1'b0;
		blank_in <= 1'b1;
		#1 `CHK({crt_de, crt_blank}, dly ? 2'b01 : 2'b10)
		@(posedge ref_clk);
		#1 `CHK({crt_de, crt_blank}, dly ? 2'b10 : 2'b01)
	endtask : crt

	// cursor modes, heights, extension, stretch, blink, enable
	task automatic t_cursor;
		logic [9:0] hx [8] = '{10'h0, 10'h20, 10'h80, 10'h80, 10'h40, 10'h40, 10'h40, 10'h0};
		wr(8'h80, 8'h10);
		for (int k = 0; k < 8; k++) begin
			wr(8'ha0, {5'h00, k[2:0]});
			`CHK(kmode, k == 7 ? 3'h0 : k[2:0])
			`CHK(k_h, hx[k])
		end
		`CHK(k_show, 1'b0)
		ext_h <= 8'h05;
		wr(8'ha0, 8'h79);
		`CHK(k_h, 10'h018)
		`CHK({k_show, k_vs, k_hs, k_org}, 4'hf)
		eng <= 2'b01;
		wr(8'ha0, 8'he1);
		`CHK({k_show, k_vs, k_hs}, 3'b000)
		blink <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 `CHK(k_show, 1'b1)
		wr(8'h80, 8'h00);
		`CHK(k_show, 1'b0)
	endtask : t_cursor

	// main sequence after a 12-cycle reset
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs;
		t_cmode;
		t_ext;
		t_pix;
		t_fill;
		t_avg;
		crt(2'b01, 8'h00, 1'b1);
		crt(2'b01, 8'h10, 1'b0);
		crt(2'b10, 8'h00, 1'b0);
		t_cursor;
		test_done;
	end

	// hang guard, several times the expected run length
	initial begin
		repeat (6000) @(posedge ref_clk);
		num_errors++;
		test_done;
	end
endmodule : ppc_top_tb
`default_nettype wire

/* rtl/ppc_consts.svh */
// constants for the pixel pipeline / cursor 1 configuration block
// assumes inclusion by bare name from every rtl file that needs them
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH

// register indices written into the index port
`define PPC_IDX_CFG0 8'h80
`define PPC_IDX_CFG1 8'h81
`define PPC_IDX_CFG2 8'h82
`define PPC_IDX_CUR1 8'ha0

// reset values
`define PPC_RST_CFG0 8'h00
`define PPC_RST_CFG1 8'h00
`define PPC_RST_CFG2 8'h00
`define PPC_RST_CUR1 8'h00

// writable bit masks, reserved bits read zero
`define PPC_MASK_CFG1 8'h1f
`define PPC_MASK_CFG2 8'h0f

// config 0 fields
`define PPC_C0_DAC8 7
`define PPC_C0_STREAM 6
`define PPC_C0_AVG 5
`define PPC_C0_CUR_EN 4
`define PPC_C0_EXT_STAT 3
`define PPC_C0_FP_OVS 2
`define PPC_C0_CRT_OVS 1
`define PPC_C0_EXT_PAL 0

// config 1 and 2 fields
`define PPC_C1_NO_DELAY 4
`define PPC_C2_GFX_GAMMA 3
`define PPC_C2_VID_GAMMA 2
`define PPC_C2_CSYNC_G 1
`define PPC_C2_PEDESTAL 0

// cursor control fields
`define PPC_K_BLINK 7
`define PPC_K_VSTR 6
`define PPC_K_HSTR 5
`define PPC_K_ORIGIN 4
`define PPC_K_VEXT 3

// colour modes
`define PPC_CM_VGA 4'h0
`define PPC_CM_PK8 4'h2
`define PPC_CM_555 4'h4
`define PPC_CM_565 4'h5
`define PPC_CM_24C 4'h6
`define PPC_CM_24U 4'h7

// cursor modes
`define PPC_KM_OFF 3'h0
`define PPC_KM_32 3'h1
`define PPC_KM_128A 3'h2
`define PPC_KM_128B 3'h3
`define PPC_KM_64A 3'h4
`define PPC_KM_64C 3'h6
`define PPC_KM_RSVD 3'h7

// cursor heights in scan lines
`define PPC_H_32 10'h020
`define PPC_H_64 10'h040
`define PPC_H_128 10'h080

// converter port selects
`define PPC_PORT_MASK 2'h0
`define PPC_PORT_WX 2'h1
`define PPC_PORT_STATE 2'h2

// crt display enable / blank delay in clocks
`define PPC_DE_DELAY 1

`endif

/* rtl/ppc_fifo.sv */
// small pixel fifo with registered fill flag
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module ppc_fifo #(
	parameter int W = 26,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk,
	input wire logic rst,
	ppc_stream_if.snk fill,
	ppc_stream_if.src drain
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic not_full;
	wire push = fill.valid && not_full;
	wire pop = drain.valid && drain.ready;

	// ready is a flop so upstream sees no combinational path
	assign fill.ready = not_full;
	assign drain.valid = (count != '0);
	assign drain.data = mem[rd_ptr];

	// pointers and occupancy
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			not_full <= 1'b1;
		end else begin
			if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
			not_full <= (count + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
		end
	end

	// storage
	always_ff @(posedge ref_clk) begin
		if (push) mem[wr_ptr] <= fill.data;
	end
endmodule : ppc_fifo
`default_nettype wire

/* rtl/ppc_pixel_avg.sv */
// flat panel pixel averaging stage with one pixel of hold
// data layout {last, replicated, rgb}; assumes one clock
`timescale 1ns/1ps
`default_nettype none
module ppc_pixel_avg #(
	parameter int W = 26
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic avg_en,
	ppc_stream_if.snk up,
	ppc_stream_if.src down
);
	logic [W-1:0] hold;
	logic hold_valid;
	logic [W-1:0] out_q;
	logic out_valid;
	logic [23:0] mix;

	// a held line-end pixel leaves without waiting for a partner
	wire can_out = !out_valid || down.ready;
	wire hold_last = hold_valid && hold[W-1];
	wire accept = up.valid && up.ready;
	wire emit_last = can_out && hold_last;
	wire emit_pair = accept && hold_valid;
	wire do_avg = avg_en && hold[W-2];
	assign up.ready = can_out && !hold_last;
	assign down.data = out_q;
	assign down.valid = out_valid;

	// per component mean, rounded down
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_mix
			wire [8:0] s = {1'b0, hold[g*8 +: 8]} + {1'b0, up.data[g*8 +: 8]};
			assign mix[g*8 +: 8] = s[8:1];
		end
	endgenerate

	// replicated pixel averaged with its follower; see R3
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hold_valid <= 1'b0;
			out_valid <= 1'b0;
			hold <= '0;
			out_q <= '0;
		end else begin
			if (emit_pair || emit_last) begin
				out_valid <= 1'b1;
				out_q <= (emit_pair && do_avg) ? {hold[W-1:24], mix} : hold; // see R3
			end else if (down.ready) begin
				out_valid <= 1'b0;
			end
			if (accept) begin
				hold <= up.data;
				hold_valid <= 1'b1;
			end else if (emit_last) begin
				hold_valid <= 1'b0;
			end
		end
	end
endmodule : ppc_pixel_avg
`default_nettype wire

/* rtl/ppc_pkg.sv */
// types shared by the pixel pipeline configuration block
// assumes nothing beyond a single clock domain
package ppc_pkg;
	typedef logic [23:0] ppc_pix_type;
	typedef logic [3:0] ppc_cmode_type;
	typedef logic [2:0] ppc_kmode_type;
	typedef logic [1:0] ppc_port_type;
endpackage : ppc_pkg

/* rtl/ppc_stream_if.sv */
// valid/ready pixel stream carrier between the block's own modules
// assumes source and sink share one clock
`timescale 1ns/1ps
`default_nettype none
interface ppc_stream_if #(parameter int W = 26);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : ppc_stream_if
`default_nettype wire

/* rtl/ppc_top.sv */
// pixel pipeline and cursor 1 configuration: indexed registers, pixel path,
// crt signal delay, converter status reads and cursor 1 controls
// assumes every input is produced on ref_clk except the host port signals,
// which are also on ref_clk; no pins from other domains
`timescale 1ns/1ps
`include "ppc_consts.svh"
`default_nettype none
// Notes on behaviour
// R1: converter components 6-bit by default, 8-bit when set
// R2: converter fed from first or second stream
// R3: flat panel replicated pixels averaged with follower
// R4: cursor 1 shown only while its enable set
// R5: extended status reads redefine three converter ports
// R6: flat panel border uses protected second overscan
// R7: crt border uses protected first overscan
// R8: extended palette addressing opens all eight locations
// R9: crt enable and blank delayed unless bit set
// R10: delay bit ignored while flat panel engine runs
// R11: software clears delay bit for standard modes
// R12: four-bit colour mode field selects pixel format
// R13: uncompressed 24-bit ignores top byte of dword
// R14: graphics gamma routes 16/24 bpp through palette
// R15: video gamma routes video through palette
// R16: composite sync added on green when set
// R17: blank pedestal applied when set
// R18: cursor 1 blinks at external blink rate
// R19: cursor 1 stretching only on flat panels
// R20: origin select picks border or active corner
// R21: vertical extension sets cursor 1 height
// R22: three-bit cursor 1 mode field selects format
// R23: extension holds lines over four minus one
// R24: reserved cursor mode shows no cursor
module ppc_top #(
	parameter int FIFO_DEPTH = 4,
	parameter int DE_DELAY = `PPC_DE_DELAY
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic host_sel_data,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	input wire logic conv_rd,
	input wire ppc_pkg::ppc_port_type conv_port,
	input wire logic [7:0] conv_mask_val,
	input wire logic [7:0] conv_wx_val,
	input wire logic [7:0] conv_state_val,
	input wire logic [7:0] red_hold,
	input wire logic [7:0] green_hold,
	input wire logic [5:0] sm_status,
	output logic [7:0] conv_rdata,
	input wire logic [31:0] first_pixel_stream,
	input wire logic [31:0] second_pixel_stream,
	input wire logic pix_valid,
	input wire logic pix_replicated,
	input wire logic pix_last,
	output logic pix_ready,
	output logic [23:0] conv_pix,
	output logic conv_valid,
	input wire logic conv_ready,
	input wire logic [1:0] display_engine_select,
	input wire logic crt_de_in,
	input wire logic crt_blank_in,
	input wire logic csync_in,
	output logic crt_de,
	output logic crt_blank,
	output logic green_sync,
	output logic blank_pedestal,
	output logic fp_border_protected,
	output logic crt_border_protected,
	output logic ext_palette_access,
	output ppc_pkg::ppc_cmode_type color_mode,
	output logic gfx_through_palette,
	output logic video_through_palette,
	input wire logic blink_phase,
	input wire logic [7:0] cursor_one_height_extension,
	output logic cursor1_show,
	output logic cursor1_vstretch,
	output logic cursor1_hstretch,
	output logic cursor1_active_origin,
	output logic [9:0] cursor1_height,
	output ppc_pkg::ppc_kmode_type cursor1_mode
);
	import ppc_pkg::*;

	localparam int PW = 26;
	logic [7:0] index_reg;
	logic [7:0] pixel_pipe_config_zero;
	logic [7:0] pixel_pipe_config_one;
	logic [7:0] pixel_pipe_config_two;
	logic [7:0] cursor_one_control;
	logic [DE_DELAY-1:0] de_taps;
	logic [DE_DELAY-1:0] blank_taps;
	logic out_full;

	// register selection from the held index
	wire hit_c0 = (index_reg == `PPC_IDX_CFG0);
	wire hit_c1 = (index_reg == `PPC_IDX_CFG1);
	wire hit_c2 = (index_reg == `PPC_IDX_CFG2);
	wire hit_k1 = (index_reg == `PPC_IDX_CUR1);
	wire data_wr = host_wr && host_sel_data;
	logic [7:0] data_view;
	always_comb begin
		if (!host_sel_data) data_view = index_reg;
		else if (hit_c0) data_view = pixel_pipe_config_zero;
		else if (hit_c1) data_view = pixel_pipe_config_one;
		else if (hit_c2) data_view = pixel_pipe_config_two;
		else if (hit_k1) data_view = cursor_one_control;
		else data_view = 8'h00;
	end

	// named config fields
	wire dac8 = pixel_pipe_config_zero[`PPC_C0_DAC8];
	wire use_second = pixel_pipe_config_zero[`PPC_C0_STREAM];
	wire avg_en = pixel_pipe_config_zero[`PPC_C0_AVG];
	wire ext_status = pixel_pipe_config_zero[`PPC_C0_EXT_STAT];
	wire no_delay = pixel_pipe_config_one[`PPC_C1_NO_DELAY];
	wire [3:0] cmode = pixel_pipe_config_one[3:0];
	wire [2:0] kmode = cursor_one_control[2:0];
	wire fp_engine = display_engine_select[1];
	wire crt_vga = display_engine_select[0];

	// host port: index and data registers; unmapped indices ignore writes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			index_reg <= 8'h00;
			pixel_pipe_config_zero <= `PPC_RST_CFG0;
			pixel_pipe_config_one <= `PPC_RST_CFG1;
			pixel_pipe_config_two <= `PPC_RST_CFG2;
			cursor_one_control <= `PPC_RST_CUR1;
			host_rdata <= 8'h00;
		end else begin
			if (host_wr && !host_sel_data) index_reg <= host_wdata;
			if (data_wr && hit_c0) pixel_pipe_config_zero <= host_wdata;
			if (data_wr && hit_c1) pixel_pipe_config_one <= host_wdata & `PPC_MASK_CFG1;
			if (data_wr && hit_c2) pixel_pipe_config_two <= host_wdata & `PPC_MASK_CFG2;
			if (data_wr && hit_k1) cursor_one_control <= host_wdata;
			if (host_rd) host_rdata <= data_view;
		end
	end

	// converter port reads, redefined in extended status mode
	logic [7:0] conv_view;
	always_comb begin
		if (conv_port == `PPC_PORT_MASK) conv_view = ext_status ? red_hold : conv_mask_val;
		else if (conv_port == `PPC_PORT_WX) conv_view = ext_status ? green_hold : conv_wx_val;
		else if (conv_port == `PPC_PORT_STATE) conv_view = ext_status ? {sm_status, 2'b00}
			: conv_state_val;
		else conv_view = 8'h00;
	end
	always_ff @(posedge ref_clk) begin
		if (rst) conv_rdata <= 8'h00;
		else if (conv_rd) conv_rdata <= conv_view; // see R5
	end

	// stream choice; uncompressed 24-bit drops the top byte of each dword
	wire [31:0] sel_word = use_second ? second_pixel_stream : first_pixel_stream; // see R2
	wire [23:0] sel_pix = sel_word[23:0]; // see R13
	ppc_stream_if #(.W(PW)) s_in ();
	ppc_stream_if #(.W(PW)) s_mid ();
	ppc_stream_if #(.W(PW)) s_out ();
	assign s_in.data = {pix_last, pix_replicated && fp_engine, sel_pix};
	assign s_in.valid = pix_valid;
	assign pix_ready = s_in.ready;

	// fifo absorbs converter stalls; averaging sits after it
	ppc_fifo #(.W(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.fill(s_in),
		.drain(s_mid)
	);
	ppc_pixel_avg #(.W(PW)) u_avg (
		.ref_clk(ref_clk),
		.rst(rst),
		.avg_en(avg_en),
		.up(s_mid),
		.down(s_out)
	);

	// converter stage: 6-bit mode sends the top six bits of each component
	wire out_load = s_out.valid && s_out.ready;
	wire [23:0] pix_word = s_out.data[23:0];
	wire [23:0] pix_six = {2'b00, pix_word[23:18], 2'b00, pix_word[15:10], 2'b00,
		pix_word[7:2]};
	assign s_out.ready = !out_full || conv_ready;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			out_full <= 1'b0;
			conv_pix <= 24'h000000;
		end else if (s_out.ready) begin
			out_full <= s_out.valid;
			if (out_load) conv_pix <= dac8 ? pix_word : pix_six; // see R1
		end
	end
	assign conv_valid = out_full;

	// crt enable/blank delay, only on the vga pipeline and never on panels
	wire delay_act = !no_delay && crt_vga && !fp_engine; // see R9, R10
	generate
		if (DE_DELAY == 1) begin : g_one
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					de_taps <= '0;
					blank_taps <= '0;
				end else begin
					de_taps <= crt_de_in;
					blank_taps <= crt_blank_in;
				end
			end
		end else begin : g_many
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					de_taps <= '0;
					blank_taps <= '0;
				end else begin
					de_taps <= {de_taps[DE_DELAY-2:0], crt_de_in};
					blank_taps <= {blank_taps[DE_DELAY-2:0], crt_blank_in};
				end
			end
		end
	endgenerate
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			crt_de <= 1'b0;
			crt_blank <= 1'b1;
		end else begin
			crt_de <= delay_act ? de_taps[DE_DELAY-1] : crt_de_in; // see R9
			crt_blank <= delay_act ? blank_taps[DE_DELAY-1] : crt_blank_in; // see R10
		end
	end

	// 16/24 bpp formats are the ones graphics gamma may route
	wire deep_mode = (cmode == `PPC_CM_555) || (cmode == `PPC_CM_565) ||
		(cmode == `PPC_CM_24C) || (cmode == `PPC_CM_24U);

	// static controls toward the converter and border logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			green_sync <= 1'b0;
			blank_pedestal <= 1'b0;
			fp_border_protected <= 1'b0;
			crt_border_protected <= 1'b0;
			ext_palette_access <= 1'b0;
			color_mode <= `PPC_CM_VGA;
			gfx_through_palette <= 1'b0;
			video_through_palette <= 1'b0;
		end else begin
			green_sync <= pixel_pipe_config_two[`PPC_C2_CSYNC_G] && csync_in; // see R16
			blank_pedestal <= pixel_pipe_config_two[`PPC_C2_PEDESTAL]; // see R17
			fp_border_protected <= pixel_pipe_config_zero[`PPC_C0_FP_OVS]; // see R6
			crt_border_protected <= pixel_pipe_config_zero[`PPC_C0_CRT_OVS]; // see R7
			ext_palette_access <= pixel_pipe_config_zero[`PPC_C0_EXT_PAL]; // see R8
			color_mode <= cmode; // see R12
			gfx_through_palette <= pixel_pipe_config_two[`PPC_C2_GFX_GAMMA] && deep_mode; // see R14
			video_through_palette <= pixel_pipe_config_two[`PPC_C2_VID_GAMMA]; // see R15
		end
	end

	// cursor height from mode, or from extension as (value+1)*4 lines
	wire mode_ok = (kmode != `PPC_KM_OFF) && (kmode != `PPC_KM_RSVD); // see R24
	wire [9:0] ext_lines = {cursor_one_height_extension, 2'b00} + 10'h004; // see R23
	logic [9:0] mode_lines;
	always_comb begin
		if (kmode == `PPC_KM_32) mode_lines = `PPC_H_32;
		else if (kmode == `PPC_KM_128A || kmode == `PPC_KM_128B) mode_lines = `PPC_H_128;
		else if (kmode >= `PPC_KM_64A && kmode <= `PPC_KM_64C) mode_lines = `PPC_H_64;
		else mode_lines = 10'h000;
	end
	wire blink_on = cursor_one_control[`PPC_K_BLINK];

	// cursor 1 controls; stretch is a panel-only feature
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cursor1_show <= 1'b0;
			cursor1_vstretch <= 1'b0;
			cursor1_hstretch <= 1'b0;
			cursor1_active_origin <= 1'b0;
			cursor1_height <= 10'h000;
			cursor1_mode <= `PPC_KM_OFF;
		end else begin
			cursor1_show <= pixel_pipe_config_zero[`PPC_C0_CUR_EN] && mode_ok &&
				(!blink_on || blink_phase); // see R4, R18, R24
			cursor1_vstretch <= cursor_one_control[`PPC_K_VSTR] && fp_engine; // see R19
			cursor1_hstretch <= cursor_one_control[`PPC_K_HSTR] && fp_engine; // see R19
			cursor1_active_origin <= cursor_one_control[`PPC_K_ORIGIN]; // see R20
			cursor1_height <= cursor_one_control[`PPC_K_VEXT] ? ext_lines : mode_lines; // see R21
			cursor1_mode <= mode_ok ? kmode : `PPC_KM_OFF; // see R22
		end
	end

	// checks
	property p_six_bit;
		@(posedge ref_clk) disable iff (rst)
		(out_load && !dac8) |=> (conv_pix[23:22] == 2'b00) && (conv_pix[15:14] == 2'b00) &&
			(conv_pix[7:6] == 2'b00);
	endproperty
	a_six_bit: assert property (p_six_bit) else $error("six-bit mode leaked top bits"); // see R1
	property p_cur_hidden;
		@(posedge ref_clk) disable iff (rst)
		!pixel_pipe_config_zero[`PPC_C0_CUR_EN] |=> !cursor1_show;
	endproperty
	a_cur_hidden: assert property (p_cur_hidden) else $error("cursor shown while off"); // see R4
	property p_rsvd_mode;
		@(posedge ref_clk) disable iff (rst)
		(kmode == `PPC_KM_RSVD) |=> !cursor1_show && (cursor1_mode == `PPC_KM_OFF);
	endproperty
	a_rsvd_mode: assert property (p_rsvd_mode) else $error("reserved cursor mode shown"); // see R24
	property p_ext_red;
		@(posedge ref_clk) disable iff (rst)
		(conv_rd && ext_status && conv_port == `PPC_PORT_MASK) |=> conv_rdata == $past(red_hold);
	endproperty
	a_ext_red: assert property (p_ext_red) else $error("mask port not red hold"); // see R5
	property p_ext_state;
		@(posedge ref_clk) disable iff (rst)
		(conv_rd && ext_status && conv_port == `PPC_PORT_STATE) |=>
			conv_rdata == {$past(sm_status), 2'b00};
	endproperty
	a_ext_state: assert property (p_ext_state) else $error("state port wrong"); // see R5
	property p_fp_nodelay;
		@(posedge ref_clk) disable iff (rst)
		fp_engine |=> crt_de == $past(crt_de_in) && crt_blank == $past(crt_blank_in);
	endproperty
	a_fp_nodelay: assert property (p_fp_nodelay) else $error("panel engine delayed de"); // see R10
	property p_vga_delay;
		@(posedge ref_clk) disable iff (rst)
		(delay_act && $past(!rst)) |=> crt_de == $past(crt_de_in, 2);
	endproperty
	a_vga_delay: assert property (p_vga_delay) else $error("vga de not delayed"); // see R9
	property p_vext_height;
		@(posedge ref_clk) disable iff (rst)
		cursor_one_control[`PPC_K_VEXT] |=>
			cursor1_height == ({2'b00, $past(cursor_one_height_extension)} + 10'h001) * 10'h004;
	endproperty
	a_vext_height: assert property (p_vext_height) else $error("extension height wrong"); // see R21
	property p_crt_stretch;
		@(posedge ref_clk) disable iff (rst)
		!fp_engine |=> !cursor1_vstretch && !cursor1_hstretch;
	endproperty
	a_crt_stretch: assert property (p_crt_stretch) else $error("stretch on crt"); // see R19
endmodule : ppc_top
`default_nettype wire
